// ---- logic/sms_regs.svh ----
// Register offsets, field positions and limits of the SMBus status block
`ifndef SMS_REGS_SVH
`define SMS_REGS_SVH

`define SMS_STATUS_OFS 12'h424
`define SMS_CTRL_OFS   12'h428
`define SMS_MASK_OFS   12'h42C

`define SMS_SLV_LSB    1
`define SMS_MST_LSB    9
`define SMS_DONE_BIT   24
`define SMS_ERR_LSB    25
`define SMS_ERR_MSB    29
`define SMS_IOM_BIT    16
`define SMS_ICS_BIT    17

`define SMS_ERR_NACK   0
`define SMS_ERR_ARB    1
`define SMS_ERR_COND   2
`define SMS_ERR_CSUM   3
`define SMS_ERR_UNMAP  4

`define SMS_ARB_LIMIT  5'h10
`define SMS_ERR_RESET  5'h00
`define SMS_MASK_RESET 5'h00

`endif

// ---- logic/sms_pkg.sv ----
// Types shared by the SMBus status block
package sms_pkg;

    typedef struct packed {
        logic nack;
        logic arb_lost;
        logic arb_won;
        logic misplaced;
    } sms_bus_evt_t;

    typedef struct packed {
        logic       start;
        logic       byte_vld;
        logic [7:0] data;
        logic       cfg_done;
        logic       unmapped;
        logic       last;
    } sms_rom_in_t;

    typedef enum logic {
        ARB_IDLE  = 1'b0,
        ARB_RETRY = 1'b1
    } sms_arb_st_t;

    typedef enum logic [1:0] {
        ROM_IDLE = 2'b00,
        ROM_LOAD = 2'b01,
        ROM_DONE = 2'b10
    } sms_rom_st_t;

endpackage

// ---- logic/sms_arb.sv ----
// Arbitration retry counter and abort for the master SMBus port
`timescale 1ns/1ps
`include "sms_regs.svh"
module sms_arb (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic lost,
    input  wire logic won,
    input  wire logic ignore,
    output logic      retry,
    output logic      abort,
    output logic      proceed
);
    import sms_pkg::*;

    typedef struct packed {
        sms_arb_st_t st;
        logic [4:0]  cnt;
        logic        retry;
        logic        abort;
        logic        proceed;
    } sms_arb_state_t;

    sms_arb_state_t s_q;
    sms_arb_state_t s_d;
    logic [4:0]     cnt_inc;

    assign cnt_inc = s_q.cnt + 5'h01;

    always_comb begin
        s_d         = s_q;
        s_d.retry   = 1'b0;
        s_d.abort   = 1'b0;
        s_d.proceed = 1'b0;
        unique case (s_q.st)
            ARB_IDLE, ARB_RETRY: begin
                if (lost && ignore) begin
                    s_d.proceed = 1'b1;
                end else if (lost && cnt_inc == `SMS_ARB_LIMIT) begin
                    s_d.abort = 1'b1;
                    s_d.cnt   = 5'h00;
                    s_d.st    = ARB_IDLE;
                end else if (lost) begin
                    s_d.retry = 1'b1;
                    s_d.cnt   = cnt_inc;
                    s_d.st    = ARB_RETRY;
                end else if (won) begin
                    s_d.cnt = 5'h00;
                    s_d.st  = ARB_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign retry   = s_q.retry;
    assign abort   = s_q.abort;
    assign proceed = s_q.proceed;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_abort_count: assert property (
        lost && !ignore && s_q.cnt == 5'h0F |=> abort && !retry)
        else $error("abort missing on sixteenth loss");
    a_retry_early: assert property (
        lost && !ignore && s_q.cnt < 5'h0F |=> retry && !abort)
        else $error("retry missing after lost arbitration");
    a_ignore_go: assert property (
        lost && ignore |=> proceed && !retry && !abort)
        else $error("ignore mode did not proceed");
    c_abort: cover property (abort);
endmodule

// ---- logic/sms_rom.sv ----
// Serial ROM load tracker: checksum, done flag and load errors
`timescale 1ns/1ps
module sms_rom (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 en,
    input  wire logic                 ignore_csum,
    input  wire sms_pkg::sms_rom_in_t rin,
    output logic                      done,
    output logic                      csum_err,
    output logic                      unmap_err
);
    import sms_pkg::*;

    typedef struct packed {
        sms_rom_st_t st;
        logic [7:0]  sum;
        logic        seen;
        logic        csum_err;
        logic        unmap_err;
    } sms_rom_state_t;

    sms_rom_state_t s_q;
    sms_rom_state_t s_d;
    logic [7:0]     sum_nx;
    logic           seen_nx;

    assign sum_nx  = rin.byte_vld ? s_q.sum + rin.data : s_q.sum;
    assign seen_nx = s_q.seen | rin.cfg_done;

    always_comb begin
        s_d           = s_q;
        s_d.csum_err  = 1'b0;
        s_d.unmap_err = 1'b0;
        unique case (s_q.st)
            ROM_IDLE: begin
                if (en && rin.start) begin
                    s_d.st   = ROM_LOAD;
                    s_d.sum  = 8'h00;
                    s_d.seen = 1'b0;
                end
            end
            ROM_LOAD: begin
                s_d.sum  = sum_nx;
                s_d.seen = seen_nx;
                if (rin.unmapped) begin
                    s_d.unmap_err = 1'b1;
                    s_d.st        = ROM_DONE;
                end else if (rin.last) begin
                    // Sum of all bytes must wrap to zero
                    s_d.csum_err = (!ignore_csum && sum_nx != 8'h00)
                                 || !seen_nx;
                    s_d.st       = ROM_DONE;
                end
            end
            ROM_DONE: begin
                s_d.st = ROM_DONE;
            end
            default: begin
                s_d.st = ROM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done      = s_q.st == ROM_DONE;
    assign csum_err  = s_q.csum_err;
    assign unmap_err = s_q.unmap_err;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ignore_csum: assert property (
        s_q.st == ROM_LOAD && rin.last && !rin.unmapped && ignore_csum
        && seen_nx |=> !csum_err)
        else $error("checksum flagged while ignored");
    a_done_after: assert property (
        s_q.st == ROM_LOAD && (rin.last || rin.unmapped) |=> done)
        else $error("done not set at end of load");
    c_load_ok: cover property (done && !csum_err && !unmap_err);
endmodule

// ---- logic/sms_status.sv ----
// SMBus status, control and error reporting with Avalon-MM access
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "sms_regs.svh"
module sms_status (
    input  wire logic                 CLOCK,
    input  wire logic                 RST_N,
    input  wire logic [11:0]          ADDRESS,
    input  wire logic                 READ,
    input  wire logic                 WRITE,
    input  wire logic [31:0]          WRITEDATA,
    input  wire logic [3:0]           BYTEENABLE,
    output logic      [31:0]          READDATA,
    output logic                      WAITREQUEST,
    input  wire logic [6:0]           SLAVE_ADDR_STRAP,
    input  wire logic [6:0]           MASTER_ADDR_STRAP,
    input  wire logic                 ROM_LOAD_MODE,
    input  wire sms_pkg::sms_bus_evt_t BUS_EVT,
    input  wire sms_pkg::sms_rom_in_t  ROM_IN,
    output logic                      RETRY_ARB,
    output logic                      ABORT_TXN,
    output logic                      PROCEED_LOST,
    output logic                      ROM_LOAD_DONE,
    output logic                      IRQ
);
    import sms_pkg::*;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        strapped;
        logic [6:0]  slave_port_address;
        logic [6:0]  master_port_address;
        logic        ignore_other_masters;
        logic        ignore_load_checksum;
        logic [4:0]  err;
        logic [4:0]  mask;
        logic        irq;
    } sms_state_t;

    sms_state_t s_q;
    sms_state_t s_d;

    logic        rom_load_done;
    logic        csum_pulse;
    logic        unmap_pulse;
    logic        abort_pulse;
    logic        req;
    logic        wr_go;
    logic        hit_status;
    logic        hit_ctrl;
    logic        hit_mask;
    logic [4:0]  evt;
    logic [4:0]  clr;
    logic [4:0]  err_nx;
    logic [31:0] status_word;
    logic [31:0] ctrl_word;
    logic [31:0] mask_word;

    sms_arb u_arb (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .lost    (BUS_EVT.arb_lost),
        .won     (BUS_EVT.arb_won),
        .ignore  (s_q.ignore_other_masters),
        .retry   (RETRY_ARB),
        .abort   (abort_pulse),
        .proceed (PROCEED_LOST)
    );

    sms_rom u_rom (
        .clk         (CLOCK),
        .rst_n       (RST_N),
        .en          (ROM_LOAD_MODE),
        .ignore_csum (s_q.ignore_load_checksum),
        .rin         (ROM_IN),
        .done        (rom_load_done),
        .csum_err    (csum_pulse),
        .unmap_err   (unmap_pulse)
    );

    // One wait state: decode in the first cycle, answer in the second
    assign req        = READ || WRITE;
    assign wr_go      = WRITE && s_q.ack;
    assign hit_status = {ADDRESS[11:2], 2'b00} == `SMS_STATUS_OFS;
    assign hit_ctrl   = {ADDRESS[11:2], 2'b00} == `SMS_CTRL_OFS;
    assign hit_mask   = {ADDRESS[11:2], 2'b00} == `SMS_MASK_OFS;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`SMS_SLV_LSB +: 7] = s_q.slave_port_address;
        status_word[`SMS_MST_LSB +: 7] = s_q.master_port_address;
        status_word[`SMS_DONE_BIT] = rom_load_done;
        status_word[`SMS_ERR_MSB:`SMS_ERR_LSB] = s_q.err;
        ctrl_word = 32'h0000_0000;
        ctrl_word[`SMS_IOM_BIT] = s_q.ignore_other_masters;
        ctrl_word[`SMS_ICS_BIT] = s_q.ignore_load_checksum;
        mask_word = 32'h0000_0000;
        mask_word[`SMS_ERR_MSB:`SMS_ERR_LSB] = s_q.mask;
    end

    always_comb begin
        evt = 5'h00;
        evt[`SMS_ERR_NACK]  = BUS_EVT.nack;
        evt[`SMS_ERR_ARB]   = abort_pulse;
        evt[`SMS_ERR_COND]  = BUS_EVT.misplaced;
        evt[`SMS_ERR_CSUM]  = csum_pulse;
        evt[`SMS_ERR_UNMAP] = unmap_pulse;
    end

    // All error bits sit in byte lane 3
    assign clr = (wr_go && hit_status && BYTEENABLE[3])
               ? WRITEDATA[`SMS_ERR_MSB:`SMS_ERR_LSB] : 5'h00;

    always_comb begin
        s_d       = s_q;
        s_d.ack   = req && !s_q.ack;
        // Straps are caught once, on the first edge after reset release
        if (!s_q.strapped) begin
            s_d.strapped            = 1'b1;
            s_d.slave_port_address  = SLAVE_ADDR_STRAP;
            s_d.master_port_address = MASTER_ADDR_STRAP;
        end
        if (req && !s_q.ack) begin
            s_d.rdata = 32'h0000_0000;
            if (READ && hit_status) begin
                s_d.rdata = status_word;
            end else if (READ && hit_ctrl) begin
                s_d.rdata = ctrl_word;
            end else if (READ && hit_mask) begin
                s_d.rdata = mask_word;
            end
        end
        if (wr_go && hit_ctrl && BYTEENABLE[2]) begin
            s_d.ignore_other_masters = WRITEDATA[`SMS_IOM_BIT];
            s_d.ignore_load_checksum = WRITEDATA[`SMS_ICS_BIT];
        end
        if (wr_go && hit_mask && BYTEENABLE[3]) begin
            s_d.mask = WRITEDATA[`SMS_ERR_MSB:`SMS_ERR_LSB];
        end
        s_d.err = err_nx;
        s_d.irq = |(s_d.err & s_d.mask);
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            s_q      <= '0;
            s_q.err  <= `SMS_ERR_RESET;
            s_q.mask <= `SMS_MASK_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign WAITREQUEST   = req && !s_q.ack;
    assign READDATA      = s_q.rdata;
    assign ABORT_TXN     = abort_pulse;
    assign ROM_LOAD_DONE = rom_load_done;
    assign IRQ           = s_q.irq;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    a_nack_sets: assert property (
        BUS_EVT.nack |=> s_q.err[`SMS_ERR_NACK])
        else $error("nack event not recorded");
    a_cond_sets: assert property (
        BUS_EVT.misplaced |=> s_q.err[`SMS_ERR_COND])
        else $error("misplaced condition not recorded");
    a_arb_sets: assert property (
        abort_pulse |=> s_q.err[`SMS_ERR_ARB])
        else $error("arbitration abort not recorded");
    a_csum_sets: assert property (
        csum_pulse |=> s_q.err[`SMS_ERR_CSUM])
        else $error("checksum error not recorded");
    a_unmap_sets: assert property (
        unmap_pulse |=> s_q.err[`SMS_ERR_UNMAP])
        else $error("unmapped init not recorded");
    a_w1c_clear: assert property (
        clr[`SMS_ERR_NACK] && !BUS_EVT.nack
        |=> !s_q.err[`SMS_ERR_NACK])
        else $error("write one did not clear nack error");
    a_sticky_err: assert property (
        s_q.err[`SMS_ERR_COND] && !clr[`SMS_ERR_COND]
        |=> s_q.err[`SMS_ERR_COND])
        else $error("error bit dropped without clear");
    a_rsvd_zero: assert property (
        s_q.ack && READ && hit_status
        |-> READDATA[0] == 1'b0 && READDATA[8] == 1'b0
            && READDATA[23:16] == 8'h00 && READDATA[31:30] == 2'b00)
        else $error("reserved status bits not zero");
    a_addr_read: assert property (
        s_q.ack && READ && hit_status && s_q.strapped
        |-> READDATA[7:1] == s_q.slave_port_address
            && READDATA[15:9] == s_q.master_port_address)
        else $error("port addresses misreported");
    a_addr_fixed: assert property (
        s_q.strapped |=> $stable(s_q.slave_port_address)
                         && $stable(s_q.master_port_address))
        else $error("port address changed after capture");
    a_done_sticky: assert property (
        rom_load_done |=> rom_load_done)
        else $error("load done flag fell");
    a_irq_level: assert property (
        IRQ == |(s_q.err & s_q.mask))
        else $error("interrupt level wrong");

    a_one_wait: assert property (
        req && !s_q.ack |=> !WAITREQUEST)
        else $error("answer not given after one wait state");
    a_wait_first: assert property (
        $rose(req) |-> WAITREQUEST)
        else $error("new request answered without a wait state");
    a_ack_pulse: assert property (
        s_q.ack |=> !s_q.ack)
        else $error("acknowledge held for two cycles");
    a_rdata_keep: assert property (
        !(req && !s_q.ack) |=> $stable(READDATA))
        else $error("read data changed without a new read");
    a_unmapped_read: assert property (
        s_q.ack && READ && !hit_status && !hit_ctrl && !hit_mask
        |-> READDATA == 32'h0000_0000)
        else $error("unmapped address did not read zero");
    a_ctrl_read: assert property (
        s_q.ack && READ && hit_ctrl
        |-> READDATA[`SMS_IOM_BIT] == s_q.ignore_other_masters
            && READDATA[`SMS_ICS_BIT] == s_q.ignore_load_checksum)
        else $error("control bits misreported");
    a_mask_read: assert property (
        s_q.ack && READ && hit_mask
        |-> READDATA[`SMS_ERR_MSB:`SMS_ERR_LSB] == s_q.mask)
        else $error("mask misreported");
    a_status_flags: assert property (
        s_q.ack && READ && hit_status
        |-> READDATA[`SMS_DONE_BIT] == $past(rom_load_done)
            && READDATA[`SMS_ERR_MSB:`SMS_ERR_LSB] == $past(s_q.err))
        else $error("status flags misreported");

    // Control and mask change only on a write that hits them
    a_ctrl_write: assert property (
        wr_go && hit_ctrl && BYTEENABLE[2]
        |=> s_q.ignore_other_masters == $past(WRITEDATA[`SMS_IOM_BIT])
            && s_q.ignore_load_checksum == $past(WRITEDATA[`SMS_ICS_BIT]))
        else $error("control write not taken");
    a_ctrl_keep: assert property (
        !(wr_go && hit_ctrl)
        |=> $stable(s_q.ignore_other_masters)
            && $stable(s_q.ignore_load_checksum))
        else $error("control bits changed without a write");
    a_mask_write: assert property (
        wr_go && hit_mask && BYTEENABLE[3]
        |=> s_q.mask == $past(WRITEDATA[`SMS_ERR_MSB:`SMS_ERR_LSB]))
        else $error("mask write not taken");
    a_mask_keep: assert property (
        !(wr_go && hit_mask) |=> $stable(s_q.mask))
        else $error("mask changed without a write");
    a_lane_guard: assert property (
        !BYTEENABLE[3] |-> clr == 5'h00)
        else $error("error cleared without its byte lane");
    a_strap_take: assert property (
        !s_q.strapped
        |=> s_q.slave_port_address == $past(SLAVE_ADDR_STRAP)
            && s_q.master_port_address == $past(MASTER_ADDR_STRAP))
        else $error("port address not captured");

    // One sticky flag per error bit; a new event beats a clear in the
    // same cycle, so no event is ever lost to a racing write
    for (genvar i = 0; i < 5; i++) begin : g_err
        assign err_nx[i] = (s_q.err[i] && !clr[i]) || evt[i];

        a_flag_sets: assert property (
            evt[i] |=> s_q.err[i])
            else $error("error event not recorded");
        a_flag_holds: assert property (
            s_q.err[i] && !clr[i] |=> s_q.err[i])
            else $error("error flag dropped without a clear");
        a_flag_clears: assert property (
            clr[i] && !evt[i] |=> !s_q.err[i])
            else $error("write one did not clear an error flag");
        a_flag_quiet: assert property (
            !s_q.err[i] && !evt[i] |=> !s_q.err[i])
            else $error("error flag rose with no event");
    end

    c_w1c: cover property (wr_go && hit_status && |clr);
    c_set_wins: cover property (|(clr & evt));
    c_irq: cover property (IRQ);
    c_ctrl_wr: cover property (wr_go && hit_ctrl);
endmodule

// ---- sim/sms_far_model.sv ----
// Far-side model: master SMBus bus events and serial ROM byte stream
`timescale 1ns/1ps
module sms_far_model (
    input  wire logic              clk,
    output sms_pkg::sms_bus_evt_t  evt,
    output sms_pkg::sms_rom_in_t   rin
);
    import sms_pkg::*;

    initial begin
        evt = '0;
        rin = '0;
    end

    // One event per cycle, held for n consecutive cycles
    task automatic pulses(input sms_bus_evt_t e, input int n);
        evt <= e;
        repeat (n) @(posedge clk);
        evt <= '0;
        // Idle edge so a following call never drives evt in this step
        @(posedge clk);
    endtask

    task automatic load(input logic [7:0] b[$], input logic cfg,
                        input logic unm);
        rin.start <= 1'b1;
        @(posedge clk);
        rin.start <= 1'b0;
        for (int i = 0; i < b.size(); i++) begin
            rin.byte_vld <= 1'b1;
            rin.data     <= b[i];
            rin.last     <= (i == b.size() - 1);
            rin.cfg_done <= cfg && (i == b.size() - 1);
            rin.unmapped <= unm && (i == 1);
            @(posedge clk);
        end
        rin.byte_vld <= 1'b0;
        rin.last     <= 1'b0;
        rin.cfg_done <= 1'b0;
        rin.unmapped <= 1'b0;
        // Idle data turns over so a stale byte never looks held
        rin.data     <= ~rin.data;
        @(posedge clk);
    endtask
endmodule

// ---- sim/smbus_master_status_test.sv ----
// Self-checking bench for the SMBus status block
`timescale 1ns/1ps
module smbus_master_status_test;
    import sms_pkg::*;
    typedef struct packed {
        logic       mode;
        logic       ign;
        logic       good;
        logic       cfg;
        logic       unm;
        logic       done;
        logic [4:0] err;
        logic [4:0] care;
    } sms_row_t;
    localparam logic [6:0] SLV = 7'h2B;
    localparam logic [6:0] MST = 7'h51;
    // Columns: mode ign good cfg unm, done, err, care
    localparam sms_row_t ROWS [6] = '{
        {5'b10110, 1'b1, 5'h00, 5'h1F},
        {5'b10010, 1'b1, 5'h08, 5'h1F},
        {5'b11010, 1'b1, 5'h00, 5'h1F},
        {5'b10100, 1'b1, 5'h08, 5'h1F},
        {5'b10111, 1'b1, 5'h10, 5'h10},
        {5'b00110, 1'b0, 5'h00, 5'h1F}};

    logic          CLOCK, RST_N, READ, WRITE, ROM_LOAD_MODE;
    logic          WAITREQUEST, RETRY_ARB, ABORT_TXN, PROCEED_LOST;
    logic          ROM_LOAD_DONE, IRQ;
    logic [11:0]   ADDRESS;
    logic [3:0]    BYTEENABLE;
    logic [31:0]   WRITEDATA, READDATA, rd, base;
    logic [7:0]    bq[$];
    sms_bus_evt_t  BUS_EVT;
    sms_rom_in_t   ROM_IN;
    int            err_total = 0, total_checks = 0;
    int            n_retry = 0, n_abort = 0, n_proceed = 0, r0, p0;

    sms_status i_sms_status (.CLOCK(CLOCK), .RST_N(RST_N),
        .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
        .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
        .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
        .SLAVE_ADDR_STRAP(SLV), .MASTER_ADDR_STRAP(MST),
        .ROM_LOAD_MODE(ROM_LOAD_MODE), .BUS_EVT(BUS_EVT), .ROM_IN(ROM_IN),
        .RETRY_ARB(RETRY_ARB), .ABORT_TXN(ABORT_TXN),
        .PROCEED_LOST(PROCEED_LOST), .ROM_LOAD_DONE(ROM_LOAD_DONE),
        .IRQ(IRQ));
    sms_far_model i_sms_far_model (.clk(CLOCK), .evt(BUS_EVT),
        .rin(ROM_IN));

    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end

    always @(posedge CLOCK) begin
        n_retry   <= n_retry + int'(RETRY_ARB);
        n_abort   <= n_abort + int'(ABORT_TXN);
        n_proceed <= n_proceed + int'(PROCEED_LOST);
    end

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen,
                     exp);
        end
    endtask

    // Avalon-MM access; request held until waitrequest is low at a rising
    // edge, and read data is taken at that same edge
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        READ      <= !w;
        WRITE     <= w;
        ADDRESS   <= a;
        WRITEDATA <= d;
        @(posedge CLOCK);
        while (WAITREQUEST !== 1'b0 && n < 20) begin
            @(posedge CLOCK);
            n++;
        end
        if (WAITREQUEST !== 1'b0) begin
            check({31'h0, WAITREQUEST}, 32'h0000_0000);
            end_sim();
        end
        rd = READDATA;
        READ  <= 1'b0;
        WRITE <= 1'b0;
        // One idle edge so the next request never lands in this step
        @(posedge CLOCK);
    endtask

    task automatic do_reset();
        RST_N <= 1'b0;
        repeat (6) @(posedge CLOCK);
        RST_N <= 1'b1;
        repeat (2) @(posedge CLOCK);
    endtask

    initial begin
        RST_N = 1'b0;
        READ = 1'b0;
        WRITE = 1'b0;
        ADDRESS = 12'h000;
        WRITEDATA = 32'h0000_0000;
        BYTEENABLE = 4'hF;
        ROM_LOAD_MODE = 1'b0;
        base = {16'h0000, MST, 1'b0, SLV, 1'b0};
        foreach (ROWS[i]) begin
            do_reset();
            ROM_LOAD_MODE <= ROWS[i].mode;
            bus(1'b1, 12'h428, {14'h0, ROWS[i].ign, 17'h0});
            bq = '{8'h12, 8'h34, ROWS[i].good ? 8'hBA : 8'hBB};
            i_sms_far_model.load(bq, ROWS[i].cfg, ROWS[i].unm);
            repeat (3) @(posedge CLOCK);
            bus(1'b0, 12'h424, 32'h0000_0000);
            check(rd[24], ROWS[i].done);
            check(ROM_LOAD_DONE, ROWS[i].done);
            check(rd[29:25] & ROWS[i].care, ROWS[i].err);
            $display("Test rom row %0d done", i);
        end

        do_reset();
        ROM_LOAD_MODE <= 1'b1;
        bus(1'b0, 12'h424, 32'h0000_0000);
        check(rd, base);
        bus(1'b0, 12'h428, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        bus(1'b0, 12'h42C, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        bus(1'b1, 12'h430, 32'hFFFF_FFFF);
        bus(1'b0, 12'h430, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        bus(1'b1, 12'h424, 32'hFFFF_FFFF);
        bus(1'b0, 12'h424, 32'h0000_0000);
        check(rd, base);
        // A second start after done must be refused
        i_sms_far_model.load('{8'h12, 8'h34, 8'hBA}, 1'b1, 1'b0);
        i_sms_far_model.load('{8'h12, 8'h34, 8'hBB}, 1'b1, 1'b0);
        repeat (3) @(posedge CLOCK);
        base = base | 32'h0100_0000;
        bus(1'b0, 12'h424, 32'h0000_0000);
        check(rd, base);
        $display("Test registers done");

        bus(1'b1, 12'h42C, 32'h0200_0000);
        i_sms_far_model.pulses(4'b1000, 1);
        repeat (2) @(posedge CLOCK);
        check(IRQ, 1'b1);
        bus(1'b1, 12'h424, 32'h0000_0000);
        bus(1'b0, 12'h424, 32'h0000_0000);
        check(rd, base | 32'h0200_0000);
        i_sms_far_model.pulses(4'b0001, 1);
        repeat (2) @(posedge CLOCK);
        bus(1'b0, 12'h424, 32'h0000_0000);
        check(rd, base | 32'h0A00_0000);
        bus(1'b1, 12'h424, 32'h0200_0000);
        check(IRQ, 1'b0);
        // Without byte lane 3 a write of one must not clear
        BYTEENABLE <= 4'h7;
        bus(1'b1, 12'h424, 32'h0800_0000);
        BYTEENABLE <= 4'hF;
        bus(1'b0, 12'h424, 32'h0000_0000);
        check(rd, base | 32'h0800_0000);
        bus(1'b1, 12'h424, 32'h0800_0000);
        $display("Test sticky errors done");

        r0 = n_retry;
        i_sms_far_model.pulses(4'b0100, 15);
        i_sms_far_model.pulses(4'b0010, 1);
        repeat (3) @(posedge CLOCK);
        check(n_abort, 0);
        i_sms_far_model.pulses(4'b0100, 16);
        repeat (3) @(posedge CLOCK);
        check(n_retry - r0, 30);
        check(n_abort, 1);
        bus(1'b0, 12'h424, 32'h0000_0000);
        check(rd, base | 32'h0400_0000);
        $display("Test arbitration done");

        bus(1'b1, 12'h428, 32'h0001_0000);
        r0 = n_retry;
        p0 = n_proceed;
        i_sms_far_model.pulses(4'b0100, 16);
        repeat (3) @(posedge CLOCK);
        check(n_proceed - p0, 16);
        check(n_retry - r0, 0);
        check(n_abort, 1);
        $display("Test ignore masters done");
        end_sim();
    end
endmodule
